// file: hdl/tx429_pkg.sv
// package: constants and types for the parallel-to-serial word transmitter
// assumes: a single 20 MHz ref_clk domain; all pins except the register port are asynchronous to it
package tx429_pkg;

  // ----------------------------------------------------------------------
  // clock and word geometry
  // ----------------------------------------------------------------------
  localparam int REF_CLK_HZ = 20000000;
  localparam int DATA_W = 16;
  localparam int WORD_W = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] NO_BIT = 6'h00;
  localparam logic [CNT_W-1:0] LAST_BIT = 6'h20;
  localparam logic [CNT_W-1:0] SYNC_BIT = 6'h08;
  localparam int GAP_W = 2;
  localparam logic [GAP_W-1:0] GAP_FIRST = 2'h0;
  localparam logic [GAP_W-1:0] GAP_LAST = 2'h3;
  localparam int TOP_BIT = 15;

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam int REG_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 2'h2;
  localparam int EV_W = 3;
  localparam int EV_SENT = 0;
  localparam int EV_XFER = 1;
  localparam int EV_OVERRUN = 2;
  localparam logic [EV_W-1:0] EV_NONE = 3'h0;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_GAP = 2'b01,
    ST_DATA = 2'b10
  } tx_state_e;

  typedef struct packed
  {
    logic word_select;
    logic [DATA_W-1:0] data;
  } load_s;

  typedef struct packed
  {
    logic a;
    logic b;
  } line_s;

  localparam line_s LINE_NULL = 2'h0;

endpackage

// file: hdl/tx429.sv
// transmitter: two 16-bit host loads become one 32-bit serial word plus gap
// assumes: host pins and the bit clock are asynchronous and pass synchronisers
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module tx429
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic tx_bit_clock,
  input wire logic write_n,
  input wire logic word_select,
  input wire logic [tx429_pkg::DATA_W-1:0] parallel_data_in,
  input wire logic odd_parity_select,
  input wire logic [tx429_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tx429_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tx429_pkg::REG_W-1:0] reg_rdata,
  output logic irq,
  output logic buffer_empty_flag,
  output logic line_out_a,
  output logic line_out_b,
  output logic serial_data,
  output logic sync_n
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  tx429_pkg::load_s ld_m;
  tx429_pkg::load_s ld_s;
  tx429_pkg::load_s ld_d;
  logic wr_m;
  logic wr_s;
  logic wr_d;
  logic clk_m;
  logic clk_s;
  logic clk_d;
  logic par_m;
  logic par_s;

  // data path carries one extra stage so it lines up with the strobe's last low sample
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ld_m <= '0;
      ld_s <= '0;
      ld_d <= '0;
      wr_m <= 1'b1;
      wr_s <= 1'b1;
      wr_d <= 1'b1;
    end
    else
    begin
      ld_m <= {word_select, parallel_data_in};
      ld_s <= ld_m;
      ld_d <= ld_s;
      wr_m <= write_n;
      wr_s <= wr_m;
      wr_d <= wr_s;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_m <= 1'b0;
      clk_s <= 1'b0;
      clk_d <= 1'b0;
      par_m <= 1'b0;
      par_s <= 1'b0;
    end
    else
    begin
      clk_m <= tx_bit_clock;
      clk_s <= clk_m;
      clk_d <= clk_s;
      par_m <= odd_parity_select;
      par_s <= par_m;
    end
  end

  // limitation: strobe pulses shorter than a ref_clk period may be missed
  logic wr_rise;
  logic tick;
  assign wr_rise = wr_s & ~wr_d;
  assign tick = clk_s & ~clk_d;

  // ----------------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------------
  logic [tx429_pkg::DATA_W-1:0] buf_lo;
  logic [tx429_pkg::DATA_W-1:0] buf_hi;
  logic xfer;
  logic load_hi;
  tx429_pkg::tx_state_e state;
  logic [tx429_pkg::GAP_W-1:0] gap_cnt;
  logic [tx429_pkg::CNT_W-1:0] cur_bit;
  logic [tx429_pkg::WORD_W-1:0] shift;

  assign load_hi = wr_rise & ~ld_d.word_select;
  assign xfer = ~buffer_empty_flag & (state == tx429_pkg::ST_GAP)
    & (gap_cnt == tx429_pkg::GAP_LAST);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      buf_lo <= '0;
      buf_hi <= '0;
    end
    else if (wr_rise)
    begin
      if (ld_d.word_select)
        buf_lo <= ld_d.data;
      else
        buf_hi <= ld_d.data;
    end
  end

  // a second-half load landing with a transfer keeps the buffer full
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      buffer_empty_flag <= 1'b1;
    else if (load_hi)
      buffer_empty_flag <= 1'b0;
    else if (xfer)
      buffer_empty_flag <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // word and gap sequencer
  // ----------------------------------------------------------------------
  logic odd_bit;
  assign odd_bit = ~^{buf_hi[tx429_pkg::TOP_BIT-1:0], buf_lo};

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= tx429_pkg::ST_GAP;
      gap_cnt <= tx429_pkg::GAP_LAST;
      cur_bit <= tx429_pkg::NO_BIT;
    end
    else if (xfer)
    begin
      state <= tx429_pkg::ST_DATA;
      cur_bit <= tx429_pkg::NO_BIT;
    end
    else if (tick)
    begin
      unique case (state)
        tx429_pkg::ST_GAP:
        begin
          if (gap_cnt != tx429_pkg::GAP_LAST)
            gap_cnt <= gap_cnt + 1'b1;
        end
        tx429_pkg::ST_DATA:
        begin
          if (cur_bit == tx429_pkg::LAST_BIT)
          begin
            state <= tx429_pkg::ST_GAP;
            gap_cnt <= tx429_pkg::GAP_FIRST;
            cur_bit <= tx429_pkg::NO_BIT;
          end
          else
            cur_bit <= cur_bit + 1'b1;
        end
      endcase
    end
  end

  // shift register is loaded only from the buffer, never from the pins
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      shift <= '0;
    else if (xfer)
    begin
      shift[tx429_pkg::DATA_W-1:0] <= buf_lo;
      shift[tx429_pkg::WORD_W-2:tx429_pkg::DATA_W] <= buf_hi[tx429_pkg::TOP_BIT-1:0];
      shift[tx429_pkg::WORD_W-1] <= par_s ? odd_bit : buf_hi[tx429_pkg::TOP_BIT];
    end
    else if (tick && state == tx429_pkg::ST_DATA && cur_bit != tx429_pkg::LAST_BIT)
      shift <= {1'b0, shift[tx429_pkg::WORD_W-1:1]};
  end

  // ----------------------------------------------------------------------
  // line outputs
  // ----------------------------------------------------------------------
  logic sending;
  assign sending = (state == tx429_pkg::ST_DATA) && (cur_bit != tx429_pkg::LAST_BIT);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_out_a <= tx429_pkg::LINE_NULL.a;
      line_out_b <= tx429_pkg::LINE_NULL.b;
      serial_data <= 1'b0;
    end
    else if (tick)
    begin
      if (sending)
      begin
        line_out_a <= shift[0];
        line_out_b <= ~shift[0];
        serial_data <= shift[0];
      end
      else
      begin
        line_out_a <= tx429_pkg::LINE_NULL.a;
        line_out_b <= tx429_pkg::LINE_NULL.b;
        serial_data <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      sync_n <= 1'b1;
    else
      sync_n <= ~((cur_bit == tx429_pkg::SYNC_BIT) && !clk_s && state == tx429_pkg::ST_DATA);
  end

  // ----------------------------------------------------------------------
  // status, mask and register port
  // ----------------------------------------------------------------------
  logic [tx429_pkg::EV_W-1:0] status;
  logic [tx429_pkg::EV_W-1:0] mask;
  logic [tx429_pkg::EV_W-1:0] events;
  logic [tx429_pkg::EV_W-1:0] clr;

  always_comb
  begin
    events = tx429_pkg::EV_NONE;
    events[tx429_pkg::EV_SENT] = tick && state == tx429_pkg::ST_DATA && cur_bit == tx429_pkg::LAST_BIT;
    events[tx429_pkg::EV_XFER] = xfer;
    events[tx429_pkg::EV_OVERRUN] = wr_rise && !buffer_empty_flag;
    clr = tx429_pkg::EV_NONE;
    if (reg_wr && reg_addr == tx429_pkg::ADDR_STATUS)
      clr = reg_wdata[tx429_pkg::EV_W-1:0];
  end

  // set wins over a same-cycle clear
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      status <= tx429_pkg::EV_NONE;
    else
      status <= (status & ~clr) | events;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      mask <= tx429_pkg::MASK_RESET;
    else if (reg_wr && reg_addr == tx429_pkg::ADDR_MASK)
      mask <= reg_wdata[tx429_pkg::EV_W-1:0];
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

  // unmapped reads and idle cycles return zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= '0;
    else
    begin
      reg_rdata <= '0;
      if (reg_rd)
      begin
        unique case (reg_addr)
          tx429_pkg::ADDR_STATUS: reg_rdata <= {5'h00, status};
          tx429_pkg::ADDR_MASK: reg_rdata <= {5'h00, mask};
          tx429_pkg::ADDR_STATE: reg_rdata <= {cur_bit, state == tx429_pkg::ST_DATA, buffer_empty_flag};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  empty_low_a: assert property (load_hi |=> !buffer_empty_flag)
    else $error("flag not low after second load");
  refill_a: assert property (xfer && !load_hi |=> buffer_empty_flag)
    else $error("flag not high after transfer");
  xfer_gap_a: assert property (xfer |-> state == tx429_pkg::ST_GAP && gap_cnt == tx429_pkg::GAP_LAST
    && !line_out_a && !line_out_b)
    else $error("transfer outside fourth gap period");
  parity_odd_a: assert property (xfer && par_s |=> ^shift)
    else $error("word parity not odd");
  top_bit_a: assert property (xfer && !par_s |=> shift[tx429_pkg::WORD_W-1] == $past(buf_hi[tx429_pkg::TOP_BIT]))
    else $error("bit 32 not the top data bit");
  bit_order_a: assert property (xfer |=> shift[tx429_pkg::DATA_W-1:0] == $past(buf_lo))
    else $error("first half not in bits 1 to 16");
  gap_start_a: assert property (events[tx429_pkg::EV_SENT] |=> state == tx429_pkg::ST_GAP
    && gap_cnt == tx429_pkg::GAP_FIRST ##0 !line_out_a && !line_out_b)
    else $error("gap not started after bit 32");
  hold_bit_a: assert property (!tick && !xfer |=> $stable(shift) && $stable(cur_bit))
    else $error("bit advanced without bit clock");
  line_bit_a: assert property (tick && sending |=> line_out_a == $past(shift[0]) && line_out_b == !line_out_a)
    else $error("line state does not follow bit");
  serial_copy_a: assert property (line_out_a || line_out_b |-> serial_data == line_out_a)
    else $error("serial output differs from line");
  sync_bit_a: assert property (!sync_n |-> $past(cur_bit) == tx429_pkg::SYNC_BIT && !$past(clk_s))
    else $error("sync low outside bit 8");
  irq_level_a: assert property (##1 irq == $past(|(status & mask)))
    else $error("interrupt does not follow status");

  late_xfer_c: cover property (load_hi ##1 xfer);
  word_sent_c: cover property (events[tx429_pkg::EV_SENT]);
  sync_pulse_c: cover property (!sync_n);
  overrun_c: cover property (events[tx429_pkg::EV_OVERRUN]);

endmodule

// file: test/host_model.sv
// partner: host that loads half-words through the strobe pins
// assumes: pins change just after a rising ref_clk edge
`timescale 1ns/1ps

module host_model
(
  input wire logic ref_clk,
  input wire logic buffer_empty_flag,
  output logic write_n,
  output logic word_select,
  output logic [tx429_pkg::DATA_W-1:0] parallel_data_in
);
  initial
  begin
    write_n = 1'b1;
    word_select = 1'b1;
    parallel_data_in = 16'h0000;
  end

  // bus scrambled after hold so stale data cannot pass
  task automatic put(input logic ws, input logic [tx429_pkg::DATA_W-1:0] d);
    @(posedge ref_clk);
    word_select <= ws;
    parallel_data_in <= d;
    repeat (3) @(posedge ref_clk);
    write_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    write_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    parallel_data_in <= ~d;
  endtask

  task automatic load(input logic [15:0] f, input logic [15:0] s, input bit wait_empty, output bit ok);
    int n;
    for (n = 0; wait_empty && buffer_empty_flag !== 1'b1 && n < 4000; n++)
      @(negedge ref_clk);
    ok = (n < 4000);
    put(1'b1, f);
    put(1'b0, s);
  endtask
endmodule

// file: test/tb.sv
// bench: random and corner loads, words checked at the line pins
// assumes: host_model drives the load pins; bit clock is ref_clk / 16
`timescale 1ns/1ps

module tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic tx_bit_clock = 1'b0;
  logic odd_parity_select = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic write_n, word_select, irq, buffer_empty_flag, line_out_a, line_out_b, serial_data, sync_n;
  logic [15:0] parallel_data_in, f, s;
  logic [7:0] reg_rdata, rd;
  logic [31:0] expq[$];
  logic [31:0] shreg;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 1024;
  int gap_len = 4;
  int nbit = 0;
  bit pend = 0;
  bit ok;

  always #25 ref_clk = ~ref_clk;

  always
  begin
    repeat (8) @(posedge ref_clk);
    tx_bit_clock <= ~tx_bit_clock;
  end

  tx429 uut
  (
    .ref_clk(ref_clk), .rstn(rstn), .tx_bit_clock(tx_bit_clock), .write_n(write_n),
    .word_select(word_select), .parallel_data_in(parallel_data_in), .odd_parity_select(odd_parity_select),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .buffer_empty_flag(buffer_empty_flag), .line_out_a(line_out_a), .line_out_b(line_out_b),
    .serial_data(serial_data), .sync_n(sync_n)
  );

  host_model host
  (
    .ref_clk(ref_clk), .buffer_empty_flag(buffer_empty_flag), .write_n(write_n),
    .word_select(word_select), .parallel_data_in(parallel_data_in)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // serial bit k sits at index k-1
  function automatic logic [31:0] build(input logic [15:0] a, input logic [15:0] b, input logic par);
    logic [31:0] w;
    w = {b, a};
    if (par)
      w[31] = ~^w[30:0];
    return w;
  endfunction

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic drain();
    int n;
    for (n = 0; expq.size() != 0 && n < 20000; n++)
      @(negedge ref_clk);
    if (n >= 20000)
    begin
      chk("drain timeout", 0, 1);
      print_verdict();
    end
    else
      repeat (32) @(negedge ref_clk);
  endtask

  // ----------------------------------------------------------------------
  // line monitor: one sample per bit period, in the low phase
  // ----------------------------------------------------------------------
  always @(negedge tx_bit_clock)
  begin
    repeat (6) @(negedge ref_clk);
    if (rstn === 1'b1)
    begin
      if ({line_out_a, line_out_b} === 2'b00)
      begin
        chk("gap data", 0, serial_data);
        chk("gap sync", 1, sync_n);
        if (nbit != 0)
          chk("bit count", 32, nbit);
        nbit = 0;
        gap_len++;
      end
      else
      begin
        if (nbit == 0 && (pend || gap_len < 4))
          chk("gap length", 4, gap_len);
        shreg[nbit] = line_out_a;
        nbit++;
        chk("line code", 1, line_out_a ^ line_out_b);
        chk("data copy", line_out_a, serial_data);
        chk("sync", nbit != 8, sync_n);
        if (nbit == 32)
        begin
          chk("word", (expq.size() != 0) ? expq.pop_front() : ~shreg, shreg);
          pend = (buffer_empty_flag === 1'b0);
          nbit = 0;
          gap_len = 0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk("empty flag", 1, buffer_empty_flag);
    chk("idle line", 0, {line_out_a, line_out_b, serial_data});
    reg_read(tx429_pkg::ADDR_MASK, rd);
    chk("mask reset", 0, rd);
    reg_write(tx429_pkg::ADDR_MASK, 8'h01);
    // repeated first half: the later load wins
    host.put(1'b1, 16'hdead);
    expq.push_back(build(16'h1234, 16'h8001, 1'b0));
    host.load(16'h1234, 16'h8001, 1'b1, ok);
    drain();
    chk("irq on", 1, irq);
    reg_read(tx429_pkg::ADDR_STATUS, rd);
    chk("status", 8'h03, rd);
    reg_write(tx429_pkg::ADDR_STATUS, 8'h07);
    reg_read(tx429_pkg::ADDR_STATUS, rd);
    chk("status clear", 0, rd);
    chk("irq off", 0, irq);
    reg_write(2'h3, 8'hff);
    reg_read(2'h3, rd);
    chk("unmapped", 0, rd);
    reg_read(tx429_pkg::ADDR_STATE, rd);
    chk("state idle", 8'h01, rd);
    for (int p = 1; p >= 0; p--)
    begin
      @(posedge ref_clk);
      odd_parity_select <= p[0];
      for (int i = 0; i < 4; i++)
      begin
        f = $random(seed);
        s = $random(seed);
        expq.push_back(build(f, s, p[0]));
        host.load(f, s, 1'b1, ok);
        chk("ready wait", 1, ok);
        repeat (6) @(negedge ref_clk);
        if (i > 0)
          chk("full flag", 0, buffer_empty_flag);
        reg_read(tx429_pkg::ADDR_STATE, rd);
        chk("state bits", (i > 0) ? 2 : 3, rd[1:0]);
      end
      drain();
    end
    // a third word over a full buffer replaces the pending one
    expq.push_back(build(16'h0f0f, 16'hf0f0, 1'b0));
    expq.push_back(build(16'h5555, 16'haaaa, 1'b0));
    host.load(16'h0f0f, 16'hf0f0, 1'b1, ok);
    host.load(16'h3333, 16'hcccc, 1'b1, ok);
    host.load(16'h5555, 16'haaaa, 1'b0, ok);
    drain();
    reg_read(tx429_pkg::ADDR_STATUS, rd);
    chk("overrun", 1, rd[tx429_pkg::EV_OVERRUN]);
    print_verdict();
  end
endmodule
